// ==== sensor_i2c_pkg.sv ====
// ****************************************************************************
// sensor_i2c_pkg: shared constants and carrier types for the sensor i2c core
// ****************************************************************************
// holds timing counts, register offsets, reset values and pin carriers.
// assumes a single 125 MHz core clock and open-drain pads outside the core.
package sensor_i2c_pkg;

  // ****************************************************************************
  // timing
  // ****************************************************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int AUX_PHASE_NS = 1300;
  localparam int AUX_PHASE_CYC = (AUX_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WDT_SHORT_US = 1250;
  localparam int WDT_LONG_US = 40000;
  localparam int WDT_SHORT_CYC = WDT_SHORT_US * 1000 / CLK_PERIOD_NS;
  localparam int WDT_LONG_CYC = WDT_LONG_US * 1000 / CLK_PERIOD_NS;
  localparam int AUX_POLL_US = 10000;
  localparam int AUX_POLL_CYC = AUX_POLL_US * 1000 / CLK_PERIOD_NS;
  // host side idle windows after a write; the core relies on them, never checks
  localparam int HOST_IDLE_PERF_NS = 2000;
  localparam int HOST_IDLE_LP_US = 450;

  // ****************************************************************************
  // addresses and reset values
  // ****************************************************************************
  localparam logic [6:0] TARGET_ADDR_BASE = 7'h18;
  localparam logic [7:0] START_ADDR_RESET = 8'h00;
  localparam logic [7:0] AUX_DEV_REG = 8'h4B;
  localparam logic [7:0] AUX_RD_REG = 8'h4D;
  localparam logic [7:0] AUX_WR_REG = 8'h4E;
  localparam logic [7:0] AUX_WDATA_REG = 8'h4F;
  localparam logic [7:0] AUX_DATA_BASE = 8'h04;
  localparam logic [6:0] AUX_DEV_RESET = 7'h10;
  localparam logic [7:0] AUX_RD_RESET = 8'h42;
  localparam logic [3:0] AUX_BURST_LAST = 4'h7;

  // ****************************************************************************
  // carriers
  // ****************************************************************************
  typedef struct packed {
    logic o;
    logic oe;
  } od_drive_t;

  typedef struct packed {
    logic bus_watchdog_enable;
    logic bus_watchdog_period_select;
  } wdt_cfg_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } byte_strobe_t;

endpackage

// ==== reg_bank_mem.sv ====
// register bank storage: 256 bytes, one write port, registered read port.
// assumes the caller arbitrates writers and tolerates one cycle read latency.
`timescale 1ns/100ps
module reg_bank_mem (
  // clock
  input wire logic core_clk_i,
  // write port
  input wire logic wr_en_i,
  input wire logic [7:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  // read port
  input wire logic [7:0] rd_addr_i,
  output logic [7:0] rd_data_o
);
  logic [7:0] mem_array [0:255];

  // contents are undefined after power-up, as for any plain register ram
  always_ff @(posedge core_clk_i)
  begin
    if (wr_en_i)
    begin
      mem_array[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem_array[rd_addr_i];
  end
endmodule // reg_bank_mem

// ==== sensor_i2c_core.sv ====
// sensor i2c core: primary i2c target with pointer, watchdog and aux master.
// assumes open-drain pads: every *_drv_o pulls low while its oe is high.
`timescale 1ns/100ps
module sensor_i2c_core #(
  parameter int WDT_SHORT_CYCLES = sensor_i2c_pkg::WDT_SHORT_CYC,
  parameter int WDT_LONG_CYCLES = sensor_i2c_pkg::WDT_LONG_CYC,
  parameter int AUX_POLL_CYCLES = sensor_i2c_pkg::AUX_POLL_CYC
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // primary bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output sensor_i2c_pkg::od_drive_t sda_drv_o,
  input wire logic address_select_pin_i,
  // nonvolatile watchdog configuration
  input wire sensor_i2c_pkg::wdt_cfg_t wdt_cfg_i,
  // secondary bus pins
  input wire logic secondary_bus_data_i,
  output sensor_i2c_pkg::od_drive_t secondary_bus_clock_drv_o,
  output sensor_i2c_pkg::od_drive_t secondary_bus_data_drv_o,
  input wire logic aux_pullup_request_i,
  output logic aux_pullup_en_o,
  // aux data path and status
  input wire logic aux_fifo_enable_i,
  output sensor_i2c_pkg::byte_strobe_t aux_fifo_o,
  output logic aux_nack_o,
  output logic target_busy_o,
  output logic wdt_fired_o
);
  import sensor_i2c_pkg::*;

  typedef enum logic [3:0] {P_IDLE, P_ADDR, P_ACK_ADDR, P_REG, P_ACK_REG, P_WR, P_ACK_WR,
                            P_RD, P_RD_ACK, P_WAIT} pri_state_t;
  typedef enum logic [3:0] {A_IDLE, A_START, A_DEVW, A_REG, A_DATA, A_RSTART, A_DEVR,
                            A_RX, A_STOP} aux_state_t;

  // ****************************************************************************
  // primary bus sampling
  // ****************************************************************************
  logic [2:0] scl_sync_reg;
  logic [2:0] sda_sync_reg;
  logic [1:0] pin_sync_reg;

  // bit 0 feeds only bit 1; bit 2 is the previous settled value for edges
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      pin_sync_reg <= 2'h0;
    end
    else
    begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_i};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_i};
      pin_sync_reg <= {pin_sync_reg[0], address_select_pin_i};
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic [6:0] own_addr;
  assign scl_rise = scl_sync_reg[1] & ~scl_sync_reg[2];
  assign scl_fall = ~scl_sync_reg[1] & scl_sync_reg[2];
  assign start_det = scl_sync_reg[1] & scl_sync_reg[2] & ~sda_sync_reg[1] & sda_sync_reg[2];
  assign stop_det = scl_sync_reg[1] & scl_sync_reg[2] & sda_sync_reg[1] & ~sda_sync_reg[2];
  assign own_addr = {TARGET_ADDR_BASE[6:1], pin_sync_reg[1]};

  // ****************************************************************************
  // primary target state machine
  // ****************************************************************************
  pri_state_t p_state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic host_ack_reg;
  logic [7:0] ptr_reg;
  logic [7:0] start_addr_reg;
  logic [7:0] mem_rdata;
  logic wdt_fire;
  logic byte_done;
  logic addr_match;
  logic pri_we;
  assign byte_done = scl_fall & (bit_cnt_reg == 4'h8);
  assign addr_match = (shift_reg[7:1] == own_addr);
  assign pri_we = (p_state_reg == P_WR) & byte_done;
  assign target_busy_o = (p_state_reg != P_IDLE);

  // watchdog reset aborts the transfer and frees the bus
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      p_state_reg <= P_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'hFF;
      host_ack_reg <= 1'b0;
    end
    else if (wdt_fire || stop_det)
    begin
      p_state_reg <= P_IDLE;
      bit_cnt_reg <= 4'h0;
    end
    else if (start_det)
    begin
      p_state_reg <= P_ADDR; // repeated start lands here too
      bit_cnt_reg <= 4'h0;
    end
    else
    begin
      unique case (p_state_reg)
        P_ADDR, P_REG, P_WR:
        begin
          if (scl_rise)
          begin
            shift_reg <= {shift_reg[6:0], sda_sync_reg[1]};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          else if (byte_done)
          begin
            bit_cnt_reg <= 4'h0;
            if (p_state_reg == P_ADDR)
            begin
              p_state_reg <= addr_match ? P_ACK_ADDR : P_WAIT;
            end
            else
            begin
              p_state_reg <= (p_state_reg == P_REG) ? P_ACK_REG : P_ACK_WR;
            end
          end
        end
        P_ACK_ADDR:
        begin
          if (scl_fall)
          begin
            p_state_reg <= shift_reg[0] ? P_RD : P_REG;
            tx_reg <= mem_rdata;
          end
        end
        P_ACK_REG, P_ACK_WR:
        begin
          if (scl_fall)
          begin
            p_state_reg <= P_WR;
          end
        end
        P_RD:
        begin
          if (scl_rise)
          begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          else if (byte_done)
          begin
            bit_cnt_reg <= 4'h0;
            p_state_reg <= P_RD_ACK;
          end
          else if (scl_fall)
          begin
            tx_reg <= {tx_reg[6:0], 1'b1};
          end
        end
        P_RD_ACK:
        begin
          if (scl_rise)
          begin
            host_ack_reg <= ~sda_sync_reg[1];
          end
          else if (scl_fall)
          begin
            // a not-acknowledge ends the stream; wait for the stop
            p_state_reg <= host_ack_reg ? P_RD : P_WAIT;
            tx_reg <= mem_rdata;
          end
        end
        P_IDLE, P_WAIT:
        begin
          bit_cnt_reg <= 4'h0;
        end
      endcase
    end
  end

  // pointer: reads restart at the last written register address
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      ptr_reg <= START_ADDR_RESET;
      start_addr_reg <= START_ADDR_RESET;
    end
    else if ((p_state_reg == P_ADDR) && byte_done && addr_match && shift_reg[0])
    begin
      ptr_reg <= start_addr_reg;
    end
    else if ((p_state_reg == P_REG) && byte_done)
    begin
      ptr_reg <= shift_reg;
      start_addr_reg <= shift_reg;
    end
    else if (pri_we || ((p_state_reg == P_RD) && byte_done))
    begin
      ptr_reg <= ptr_reg + 8'h01;
    end
  end

  // registered pad drive; releases the line in the host ack slot
  logic sda_oe_reg;
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      sda_oe_reg <= 1'b0;
    end
    else
    begin
      sda_oe_reg <= (p_state_reg == P_ACK_ADDR) || (p_state_reg == P_ACK_REG) ||
                    (p_state_reg == P_ACK_WR) || ((p_state_reg == P_RD) && !tx_reg[7]);
    end
  end
  assign sda_drv_o = '{o: 1'b0, oe: sda_oe_reg};

  // ****************************************************************************
  // bus watchdog
  // ****************************************************************************
  logic [22:0] wdt_cnt_reg;
  logic [22:0] wdt_limit;
  assign wdt_limit = wdt_cfg_i.bus_watchdog_period_select ? 23'(WDT_LONG_CYCLES - 1)
                                                          : 23'(WDT_SHORT_CYCLES - 1);
  assign wdt_fire = wdt_cfg_i.bus_watchdog_enable && (wdt_cnt_reg == wdt_limit);

  // counts only while we hold data low and the clock stands still
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      wdt_cnt_reg <= 23'h0;
      wdt_fired_o <= 1'b0;
    end
    else
    begin
      wdt_fired_o <= wdt_fire;
      if (!wdt_cfg_i.bus_watchdog_enable || !sda_oe_reg || scl_rise || scl_fall || wdt_fire)
      begin
        wdt_cnt_reg <= 23'h0;
      end
      else
      begin
        wdt_cnt_reg <= wdt_cnt_reg + 23'h1;
      end
    end
  end

  // ****************************************************************************
  // shadow copies of the forwarding registers
  // ****************************************************************************
  logic [6:0] aux_dev_reg;
  logic [7:0] aux_rd_reg;
  logic [7:0] aux_wr_reg;
  logic [7:0] aux_wdata_reg;
  logic wr_pend_reg;
  logic aux_take_wr;
  aux_state_t a_state_reg;

  // a host write to the data register queues one secondary write
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      aux_dev_reg <= AUX_DEV_RESET;
      aux_rd_reg <= AUX_RD_RESET;
      aux_wr_reg <= 8'h00;
      aux_wdata_reg <= 8'h00;
      wr_pend_reg <= 1'b0;
    end
    else
    begin
      if (pri_we && (ptr_reg == AUX_DEV_REG)) aux_dev_reg <= shift_reg[6:0];
      if (pri_we && (ptr_reg == AUX_RD_REG)) aux_rd_reg <= shift_reg;
      if (pri_we && (ptr_reg == AUX_WR_REG)) aux_wr_reg <= shift_reg;
      if (pri_we && (ptr_reg == AUX_WDATA_REG)) aux_wdata_reg <= shift_reg;
      // set wins over the clear of a request being taken
      if (pri_we && (ptr_reg == AUX_WDATA_REG)) wr_pend_reg <= 1'b1;
      else if (aux_take_wr) wr_pend_reg <= 1'b0;
    end
  end

  // ****************************************************************************
  // secondary bus master
  // ****************************************************************************
  logic [1:0] secondary_bus_data_sync_reg;
  logic [7:0] ph_div_reg;
  logic [1:0] ph_reg;
  logic [3:0] slot_reg;
  logic [3:0] rx_idx_reg;
  logic [7:0] rx_shift_reg;
  logic ack_bad_reg;
  logic op_read_reg;
  logic [22:0] poll_cnt_reg;
  logic poll_due_reg;
  logic tick;
  logic slot_end;
  logic [7:0] tx_byte;
  logic a_scl_low;
  logic a_sda_low;
  logic a_scl_reg;
  logic a_sda_reg;
  assign tick = (ph_div_reg == 8'(AUX_PHASE_CYC - 1));
  assign slot_end = tick && (ph_reg == 2'h3);
  assign aux_take_wr = (a_state_reg == A_IDLE) && wr_pend_reg;

  always_comb
  begin
    unique case (a_state_reg)
      A_DEVW: tx_byte = {aux_dev_reg, 1'b0};
      A_REG: tx_byte = op_read_reg ? aux_rd_reg : aux_wr_reg;
      A_DEVR: tx_byte = {aux_dev_reg, 1'b1};
      default: tx_byte = aux_wdata_reg;
    endcase
  end

  // pin levels per quarter-bit phase; no arbitration, we own this bus
  always_comb
  begin
    a_scl_low = (ph_reg == 2'h0) || (ph_reg == 2'h3);
    a_sda_low = 1'b0;
    unique case (a_state_reg)
      A_IDLE: a_scl_low = 1'b0;
      A_START, A_RSTART: a_sda_low = (ph_reg >= 2'h2);
      A_STOP:
      begin
        a_scl_low = (ph_reg == 2'h0);
        a_sda_low = (ph_reg != 2'h3);
      end
      A_RX: a_sda_low = (slot_reg == 4'h8) && (rx_idx_reg != AUX_BURST_LAST);
      A_DEVW, A_REG, A_DATA, A_DEVR: a_sda_low = (slot_reg != 4'h8) && !tx_byte[3'(4'h7 - slot_reg)];
    endcase
  end

  // poll timer raises a read request every poll period
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      poll_cnt_reg <= 23'h0;
      poll_due_reg <= 1'b0;
    end
    else
    begin
      poll_cnt_reg <= (poll_cnt_reg == 23'(AUX_POLL_CYCLES - 1)) ? 23'h0 : poll_cnt_reg + 23'h1;
      if (poll_cnt_reg == 23'(AUX_POLL_CYCLES - 1)) poll_due_reg <= 1'b1;
      else if ((a_state_reg == A_IDLE) && !wr_pend_reg) poll_due_reg <= 1'b0;
    end
  end

  // transaction sequencer; pending writes go ahead of polling
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      a_state_reg <= A_IDLE;
      ph_div_reg <= 8'h00;
      ph_reg <= 2'h0;
      slot_reg <= 4'h0;
      rx_idx_reg <= 4'h0;
      rx_shift_reg <= 8'h00;
      ack_bad_reg <= 1'b0;
      op_read_reg <= 1'b0;
      secondary_bus_data_sync_reg <= 2'h3;
      a_scl_reg <= 1'b0;
      a_sda_reg <= 1'b0;
    end
    else
    begin
      secondary_bus_data_sync_reg <= {secondary_bus_data_sync_reg[0], secondary_bus_data_i};
      a_scl_reg <= a_scl_low;
      a_sda_reg <= a_sda_low;
      ph_div_reg <= (tick || (a_state_reg == A_IDLE)) ? 8'h00 : ph_div_reg + 8'h01;
      if (tick) ph_reg <= ph_reg + 2'h1;
      if (tick && (ph_reg == 2'h2))
      begin
        rx_shift_reg <= {rx_shift_reg[6:0], secondary_bus_data_sync_reg[1]};
      end
      unique case (a_state_reg)
        A_IDLE:
        begin
          ph_reg <= 2'h0;
          slot_reg <= 4'h0;
          rx_idx_reg <= 4'h0;
          if (wr_pend_reg || poll_due_reg)
          begin
            op_read_reg <= !wr_pend_reg;
            a_state_reg <= A_START;
          end
        end
        A_START: if (slot_end) a_state_reg <= A_DEVW;
        A_RSTART: if (slot_end) a_state_reg <= A_DEVR;
        A_STOP: if (slot_end) a_state_reg <= A_IDLE;
        A_DEVW, A_REG, A_DATA, A_DEVR, A_RX:
        begin
          if (slot_end && (slot_reg != 4'h8))
          begin
            slot_reg <= slot_reg + 4'h1;
          end
          else if (slot_end)
          begin
            slot_reg <= 4'h0;
            // in tx slots the last sample is the target's acknowledge bit
            ack_bad_reg <= (a_state_reg != A_RX) && rx_shift_reg[0];
            if ((a_state_reg != A_RX) && rx_shift_reg[0]) a_state_reg <= A_STOP;
            else if (a_state_reg == A_DEVW) a_state_reg <= A_REG;
            else if (a_state_reg == A_REG) a_state_reg <= op_read_reg ? A_RSTART : A_DATA;
            else if (a_state_reg == A_DATA) a_state_reg <= A_STOP;
            else if (a_state_reg == A_DEVR) a_state_reg <= A_RX;
            else if (rx_idx_reg == AUX_BURST_LAST) a_state_reg <= A_STOP;
            else rx_idx_reg <= rx_idx_reg + 4'h1;
          end
        end
      endcase
    end
  end
  assign secondary_bus_clock_drv_o = '{o: 1'b0, oe: a_scl_reg};
  assign secondary_bus_data_drv_o = '{o: 1'b0, oe: a_sda_reg};
  assign aux_nack_o = ack_bad_reg;

  // ****************************************************************************
  // received bytes into data registers and fifo port
  // ****************************************************************************
  logic aux_byte;
  logic mw_pend_reg;
  logic [7:0] mw_addr_reg;
  logic [7:0] mw_data_reg;
  assign aux_byte = (a_state_reg == A_RX) && (slot_reg == 4'h8) && tick && (ph_reg == 2'h0);

  // host writes own the port; an aux byte waits a cycle at most
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      mw_pend_reg <= 1'b0;
      mw_addr_reg <= 8'h00;
      mw_data_reg <= 8'h00;
      aux_fifo_o <= '0;
      aux_pullup_en_o <= 1'b0;
    end
    else
    begin
      aux_pullup_en_o <= aux_pullup_request_i;
      aux_fifo_o.valid <= aux_byte && aux_fifo_enable_i;
      if (aux_byte) aux_fifo_o.data <= rx_shift_reg;
      if (aux_byte)
      begin
        mw_pend_reg <= 1'b1;
        mw_addr_reg <= AUX_DATA_BASE + {4'h0, rx_idx_reg};
        mw_data_reg <= rx_shift_reg;
      end
      else if (!pri_we) mw_pend_reg <= 1'b0;
    end
  end

  reg_bank_mem u_bank (
    .core_clk_i(core_clk_i),
    .wr_en_i(pri_we || mw_pend_reg),
    .wr_addr_i(pri_we ? ptr_reg : mw_addr_reg),
    .wr_data_i(pri_we ? shift_reg : mw_data_reg),
    .rd_addr_i(ptr_reg),
    .rd_data_o(mem_rdata)
  );

  // ****************************************************************************
  // assertions
  // ****************************************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_RELEASE_ON_ACK: assert property ((p_state_reg == P_RD_ACK) [*2] |-> !sda_drv_o.oe)
    else $error("data line driven during host ack slot");
  AST_PTR_STEP: assert property ((p_state_reg == P_RD) && byte_done
    |=> (ptr_reg == $past(ptr_reg) + 8'h01) && (p_state_reg == P_RD_ACK))
    else $error("pointer did not advance after a read byte");
  AST_READ_START: assert property ((p_state_reg == P_ADDR) && byte_done && addr_match
    && shift_reg[0] |=> ptr_reg == start_addr_reg)
    else $error("read did not restart at the written address");
  AST_WDT_ABORT: assert property (wdt_fire && !start_det |=> p_state_reg == P_IDLE ##1 !sda_drv_o.oe)
    else $error("watchdog did not reset the target");
  AST_WDT_OFF: assert property (!wdt_cfg_i.bus_watchdog_enable |=> wdt_cnt_reg == 23'h0)
    else $error("watchdog counted while disabled");
  AST_AUX_IDLE: assert property ((a_state_reg == A_IDLE) [*2] |-> !secondary_bus_clock_drv_o.oe)
    else $error("secondary clock driven while idle");
  AST_FIFO_GATE: assert property (aux_fifo_o.valid |-> $past(aux_fifo_enable_i) && $past(aux_byte))
    else $error("fifo strobe without enable or byte");
  AST_FWD_WRITE: assert property (aux_take_wr |=> (a_state_reg == A_START) && !op_read_reg)
    else $error("queued write was not forwarded");
  AST_PULLUP_RESET: assert property ($rose(rst_n_i) |-> !aux_pullup_en_o)
    else $error("secondary pull-up enabled out of reset");
  AST_OWN_ADDR: assert property ((p_state_reg == P_ACK_ADDR) |-> shift_reg[7:1]
    == {TARGET_ADDR_BASE[6:1], pin_sync_reg[1]})
    else $error("acknowledged a foreign address");
endmodule // sensor_i2c_core

// ==== host_bus_model.sv ====
// host side of the primary bus: drives the clock and pulls the data wire low.
// assumes the core sees both lines through its own sync flops.
`timescale 1ns/100ps
module host_bus_model (
  // bus lines
  output logic scl_o,
  output logic sda_low_o,
  input wire logic sda_i
);
  import sensor_i2c_pkg::*;
  // ten core cycles per phase, well over the four-cycle minimum
  localparam int HALF_NS = 80;
  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // data falls while clock is high; also used as repeated start
  task automatic start_cond();
    sda_low_o = 1'b0;
    #HALF_NS scl_o = 1'b1;
    #HALF_NS sda_low_o = 1'b1;
    #HALF_NS scl_o = 1'b0;
    #HALF_NS;
  endtask
  // clock low first so the data move never reads as a start
  task automatic stop_cond();
    scl_o = 1'b0;
    #HALF_NS sda_low_o = 1'b1;
    #HALF_NS scl_o = 1'b1;
    #HALF_NS sda_low_o = 1'b0;
    #HALF_NS;
  endtask
  // data changes only a full phase after the clock fell
  task automatic bit_io(input logic b, output logic r);
    sda_low_o = ~b;
    #HALF_NS scl_o = 1'b1;
    #HALF_NS r = sda_i;
    scl_o = 1'b0;
    #HALF_NS;
  endtask
  // eight bits msb first, then the acknowledge slot
  task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
    output logic ack_out);
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(ack_in, ack_out);
  endtask
  // address byte, then the clock is parked high inside the acknowledge slot
  task automatic stall_ack(input logic [7:0] tx);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], r);
    sda_low_o = 1'b0;
    #HALF_NS scl_o = 1'b1;
  endtask
  // quiet bus after a write; the long wait covers suspend and low power
  task automatic idle_after_write(input logic low_power);
    #(low_power ? HOST_IDLE_LP_US * 1000 : HOST_IDLE_PERF_NS);
  endtask
endmodule // host_bus_model

// ==== testbench.sv ====
// self-checking bench for the sensor i2c core: primary reads, watchdog, aux bus.
// assumes pull-ups on every wire and one stand-in target on the secondary bus.
`timescale 1ns/100ps
module testbench;
  import sensor_i2c_pkg::*;
  logic core_clk_i, rst_n_i, scl, host_low, sda, adr_sel, aux_req, aux_fifo_en;
  logic aux_pu, aux_nack, busy, fired, ak, mag_hold;
  logic [7:0] rx;
  wdt_cfg_t wdt_cfg;
  od_drive_t sda_drv, sclk_drv, sdat_drv;
  byte_strobe_t fifo;
  int bad_count = 0;
  int tests_run = 0;
  // wired-and of host and core on the primary data line
  assign sda = ~(host_low | sda_drv.oe);
  host_bus_model u_host (.scl_o(scl), .sda_low_o(host_low), .sda_i(sda));
  // secondary data: the core and a single stuck-low target stand-in only
  sensor_i2c_core #(.WDT_SHORT_CYCLES(200), .WDT_LONG_CYCLES(400), .AUX_POLL_CYCLES(2000)) u_dut (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda), .sda_drv_o(sda_drv),
    .address_select_pin_i(adr_sel), .wdt_cfg_i(wdt_cfg),
    .secondary_bus_data_i(~(sdat_drv.oe | mag_hold)), .secondary_bus_clock_drv_o(sclk_drv),
    .secondary_bus_data_drv_o(sdat_drv),
    .aux_pullup_request_i(aux_req), .aux_pullup_en_o(aux_pu), .aux_fifo_enable_i(aux_fifo_en),
    .aux_fifo_o(fifo), .aux_nack_o(aux_nack), .target_busy_o(busy), .wdt_fired_o(fired));
  initial
  begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (bad_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // host to core byte, acknowledge expected as given
  task automatic send(input logic [7:0] b, input logic exp_ack);
    u_host.xfer(b, 1'b1, rx, ak);
    check({7'h00, ak}, {7'h00, exp_ack});
  endtask
  // core to host byte; nack ends the read
  task automatic recv(input logic [7:0] exp, input logic nack);
    u_host.xfer(8'hFF, nack, rx, ak);
    check(rx, exp);
  endtask
  // watchdog: a hang cut short counts as a mismatch
  initial
  begin
    #700000;
    bad_count++;
    tally_and_finish();
  end
  initial
  begin
    int n;
    int lim;
    rst_n_i = 1'b0;
    adr_sel = 1'b0;
    wdt_cfg = '0;
    aux_req = 1'b1;
    aux_fifo_en = 1'b1;
    mag_hold = 1'b0;
    repeat (8) @(posedge core_clk_i);
    check({7'h00, aux_pu}, 8'h00);
    #1 rst_n_i = 1'b1;
    repeat (4) @(posedge core_clk_i);
    #1 check({7'h00, aux_pu}, 8'h01);
    u_host.start_cond();
    check({7'h00, busy}, 8'h01);
    send({7'h19, 1'b0}, 1'b1);
    u_host.stop_cond();
    check({7'h00, busy}, 8'h00);
    u_host.start_cond();
    send({7'h18, 1'b0}, 1'b0);
    send(8'h20, 1'b0);
    send(8'hA5, 1'b0);
    send(8'h5A, 1'b0);
    u_host.stop_cond();
    // idle after a write before the next access
    u_host.idle_after_write(1'b0);
    u_host.start_cond();
    send({7'h18, 1'b0}, 1'b0);
    send(8'h20, 1'b0);
    u_host.start_cond();
    send({7'h18, 1'b1}, 1'b0);
    recv(8'hA5, 1'b0);
    recv(8'h5A, 1'b1);
    u_host.bit_io(1'b1, ak);
    check({7'h00, ak}, 8'h01);
    u_host.stop_cond();
    u_host.start_cond();
    send({7'h18, 1'b1}, 1'b0);
    recv(8'hA5, 1'b1);
    u_host.stop_cond();
    adr_sel = 1'b1;
    #200;
    u_host.start_cond();
    send({7'h19, 1'b1}, 1'b0);
    recv(8'hA5, 1'b1);
    u_host.stop_cond();
    // short period, long period, then disabled
    for (int k = 0; k < 3; k++)
    begin
      wdt_cfg = '{k < 2, k == 1};
      lim = (k == 1) ? 400 : 200;
      u_host.start_cond();
      u_host.stall_ack({7'h19, 1'b0});
      n = 0;
      while (fired !== 1'b1 && n < 600)
      begin
        @(posedge core_clk_i);
        n++;
      end
      check({7'h00, n >= lim - 4 && n <= lim + 12}, {7'h00, k < 2});
      #1 check({7'h00, sda_drv.oe}, {7'h00, k == 2});
      u_host.stop_cond();
    end
    // the core polls the magnetometer alone; with no answer it stops on nack
    n = 0;
    while (aux_nack !== 1'b1 && n < 30000)
    begin
      @(posedge core_clk_i);
      n++;
    end
    check({7'h00, aux_nack}, 8'h01);
    // a host write to the forwarding data register queues a secondary write
    u_host.start_cond();
    send({7'h19, 1'b0}, 1'b0);
    send(AUX_WDATA_REG, 1'b0);
    send(8'h3C, 1'b0);
    u_host.stop_cond();
    u_host.idle_after_write(1'b0);
    // a target holding data low target_acknowledge every byte and returns zeros
    mag_hold = 1'b1;
    n = 0;
    while (fifo.valid !== 1'b1 && n < 60000)
    begin
      @(negedge core_clk_i);
      n++;
    end
    check(fifo.data, 8'h00);
    check({5'h00, fifo.valid, sclk_drv.oe, sdat_drv.oe}, 8'h07);
    check({7'h00, aux_nack}, 8'h00);
    // the first burst byte must have landed in the data registers
    u_host.start_cond();
    send({7'h19, 1'b0}, 1'b0);
    send(AUX_DATA_BASE, 1'b0);
    u_host.start_cond();
    send({7'h19, 1'b1}, 1'b0);
    recv(8'h00, 1'b1);
    u_host.stop_cond();
    tally_and_finish();
  end
endmodule // testbench
